// ---- b3sp_pkg.sv ----
// Package for the buck3 set-point register bank: offsets, fields, reset values, decode constants.
// Assumes an 8-bit register port fed by the device's control-bus slave.
package b3sp_pkg;
    localparam logic [7:0] B3A_NORMAL_OFS = 8'h3c;
    localparam logic [7:0] B3A_STANDBY_OFS = 8'h3d;
    localparam logic [7:0] B3A_SLEEP_OFS = 8'h3e;
    localparam logic [7:0] B3A_MODE_OFS = 8'h3f;
    localparam logic [7:0] B3A_CONF_OFS = 8'h40;
    localparam logic [7:0] B3B_NORMAL_OFS = 8'h43;
    localparam logic [7:0] B3B_STANDBY_OFS = 8'h44;
    localparam logic [7:0] B3B_SLEEP_OFS = 8'h45;
    localparam logic [7:0] B3B_MODE_OFS = 8'h46;
    localparam logic [7:0] B3B_CONF_OFS = 8'h47;
    localparam int RANGE_BIT = 6;
    localparam logic [7:0] SETPOINT_WMASK = 8'h3f;
    localparam logic [7:0] MODE_WMASK = 8'h2f;
    localparam logic [7:0] CONF_WMASK = 8'hff;
    localparam logic [7:0] SETPOINT_RESET = 8'h00;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] CONF_RESET = 8'h00;
    // Highest defined code in the high range; above it is reserved
    localparam logic [5:0] HIGH_LAST_CODE = 6'h32;
    // Target in millivolts: low = base + 25 mV * code, high = base + 50 mV * code
    localparam logic [11:0] LOW_BASE_MV = 12'h190;
    localparam logic [11:0] HIGH_BASE_MV = 12'h320;
    localparam logic [11:0] LOW_STEP_MV = 12'h019;
    localparam logic [11:0] HIGH_STEP_MV = 12'h032;

    typedef enum logic [2:0] {
        B3SP_NORMAL = 3'b001,
        B3SP_STANDBY = 3'b010,
        B3SP_SLEEP = 3'b100
    } b3sp_opmode_t;

    typedef struct packed {
        logic [1:0] voltage_transition_speed;
        logic [1:0] phase_clock;
        logic [1:0] switch_freq;
        logic current_limit_select;
        logic [3:0] switching_mode;
        logic sleep_pfm;
    } b3sp_chan_ctrl_t;

    typedef struct packed {
        logic [6:0] code;
        logic [11:0] target_mv;
        logic valid;
    } b3sp_target_t;
endpackage

// ---- b3sp_bank.sv ----
// Register bank and set-point decode for the dual-channel buck3 regulator.
// Assumes a byte register port from the control-bus slave, synchronous to clk,
// and a strapped range bit per channel held steady around reset release.
`timescale 1ns/10ps

module b3sp_bank
    import b3sp_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    // Range straps from default configuration or one-time memory
    input wire logic range_strap_a,
    input wire logic range_strap_b,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_hit,
    // Operating mode per channel
    input wire b3sp_opmode_t opmode_a,
    input wire b3sp_opmode_t opmode_b,
    // Regulator controls
    output b3sp_chan_ctrl_t ctrl_a,
    output b3sp_chan_ctrl_t ctrl_b,
    output b3sp_target_t target_a,
    output b3sp_target_t target_b
);
    localparam int NREG = 10;
    localparam logic [7:0] OFS [NREG] = '{B3A_NORMAL_OFS, B3A_STANDBY_OFS, B3A_SLEEP_OFS,
        B3A_MODE_OFS, B3A_CONF_OFS, B3B_NORMAL_OFS, B3B_STANDBY_OFS, B3B_SLEEP_OFS,
        B3B_MODE_OFS, B3B_CONF_OFS};
    localparam logic [7:0] WMASK [NREG] = '{SETPOINT_WMASK, SETPOINT_WMASK, SETPOINT_WMASK,
        MODE_WMASK, CONF_WMASK, SETPOINT_WMASK, SETPOINT_WMASK, SETPOINT_WMASK,
        MODE_WMASK, CONF_WMASK};
    localparam logic [7:0] RSTV [NREG] = '{SETPOINT_RESET, SETPOINT_RESET, SETPOINT_RESET,
        MODE_RESET, CONF_RESET, SETPOINT_RESET, SETPOINT_RESET, SETPOINT_RESET,
        MODE_RESET, CONF_RESET};

    // Slot of each register; channel b's group repeats channel a's from B_GROUP on
    localparam int A_NORMAL = 0;
    localparam int A_STANDBY = 1;
    localparam int A_SLEEP = 2;
    localparam int A_MODE = 3;
    localparam int A_CONF = 4;
    localparam int B_GROUP = 5;

    logic [7:0] regs_q [NREG];
    logic [7:0] regs_d [NREG];
    logic range_a_q, range_a_d, range_b_q, range_b_d;
    logic strap_done_q, strap_done_d;
    logic [7:0] rdata_q, rdata_d;
    b3sp_target_t target_a_q, target_a_d, target_b_q, target_b_d;

    // Register writes; the range bit is masked out of every set-point write
    always_comb
    begin
        for (int i = 0; i < NREG; i++)
        begin
            regs_d[i] = regs_q[i];
            if (reg_wr && reg_addr == OFS[i])
            begin
                regs_d[i] = reg_wdata & WMASK[i];
            end
        end
    end

    // Straps are sampled once after reset release, never under the async reset
    // Limitation: a strap that moves after release is ignored until the next reset
    always_comb
    begin
        strap_done_d = 1'b1;
        range_a_d = strap_done_q ? range_a_q : range_strap_a;
        range_b_d = strap_done_q ? range_b_q : range_strap_b;
    end

    function automatic logic [7:0] view(input int i, input logic rng);
        logic [7:0] v;
        v = regs_q[i];
        if (WMASK[i] == SETPOINT_WMASK)
        begin
            v[RANGE_BIT] = rng;
        end
        return v;
    endfunction

    // Read mux: unmapped addresses read zero and drop reg_hit
    always_comb
    begin
        rdata_d = rdata_q;
        reg_hit = 1'b0;
        for (int i = 0; i < NREG; i++)
        begin
            if (reg_addr == OFS[i])
            begin
                reg_hit = 1'b1;
            end
        end
        if (reg_rd)
        begin
            rdata_d = 8'h00;
            for (int i = 0; i < NREG; i++)
            begin
                if (reg_addr == OFS[i])
                begin
                    // The latch's next value lets a read on the first edge see the strap
                    rdata_d = view(i, (i < B_GROUP) ? range_a_d : range_b_d);
                end
            end
        end
    end

    function automatic b3sp_target_t decode(input b3sp_target_t prev, input logic rng,
                                            input logic [5:0] code);
        b3sp_target_t t;
        t = prev;
        if (!rng)
        begin
            t.code = {1'b0, code};
            t.target_mv = LOW_BASE_MV + LOW_STEP_MV * {6'h00, code};
            t.valid = 1'b1;
        end
        else if (code <= HIGH_LAST_CODE)
        begin
            t.code = {1'b1, code};
            t.target_mv = HIGH_BASE_MV + HIGH_STEP_MV * {6'h00, code};
            t.valid = 1'b1;
        end
        // Reserved high codes hold the last good target rather than glitch the rail
        return t;
    endfunction

    function automatic logic [5:0] pick(input b3sp_opmode_t m, input logic [7:0] n,
                                        input logic [7:0] s, input logic [7:0] z);
        logic [5:0] c;
        unique case (m)
            B3SP_NORMAL: c = n[5:0];
            B3SP_STANDBY: c = s[5:0];
            B3SP_SLEEP: c = z[5:0];
            default: c = n[5:0];
        endcase
        return c;
    endfunction

    // Each channel sees only its own register group; nothing is decoded until the
    // straps are latched, so no target ever carries the wrong range
    always_comb
    begin
        target_a_d = target_a_q;
        target_b_d = target_b_q;
        if (strap_done_q)
        begin
            target_a_d = decode(target_a_q, range_a_q,
                pick(opmode_a, regs_q[A_NORMAL], regs_q[A_STANDBY], regs_q[A_SLEEP]));
            target_b_d = decode(target_b_q, range_b_q,
                pick(opmode_b, regs_q[B_GROUP + A_NORMAL], regs_q[B_GROUP + A_STANDBY],
                regs_q[B_GROUP + A_SLEEP]));
        end
    end

    always_ff @(posedge clk or posedge reset)
    begin
        if (reset)
        begin
            for (int i = 0; i < NREG; i++)
            begin
                regs_q[i] <= RSTV[i];
            end
            range_a_q <= 1'b0;
            range_b_q <= 1'b0;
            strap_done_q <= 1'b0;
            rdata_q <= 8'h00;
            target_a_q <= '0;
            target_b_q <= '0;
        end
        else
        begin
            regs_q <= regs_d;
            range_a_q <= range_a_d;
            range_b_q <= range_b_d;
            strap_done_q <= strap_done_d;
            rdata_q <= rdata_d;
            target_a_q <= target_a_d;
            target_b_q <= target_b_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign target_a = target_a_q;
    assign target_b = target_b_q;

    // Control fields come straight from the mode and configuration registers
    always_comb
    begin
        ctrl_a.voltage_transition_speed = regs_q[A_CONF][7:6];
        ctrl_a.phase_clock = regs_q[A_CONF][5:4];
        ctrl_a.switch_freq = regs_q[A_CONF][3:2];
        ctrl_a.current_limit_select = regs_q[A_CONF][0];
        ctrl_a.switching_mode = regs_q[A_MODE][3:0];
        ctrl_a.sleep_pfm = regs_q[A_MODE][5];
        ctrl_b.voltage_transition_speed = regs_q[B_GROUP + A_CONF][7:6];
        ctrl_b.phase_clock = regs_q[B_GROUP + A_CONF][5:4];
        ctrl_b.switch_freq = regs_q[B_GROUP + A_CONF][3:2];
        ctrl_b.current_limit_select = regs_q[B_GROUP + A_CONF][0];
        ctrl_b.switching_mode = regs_q[B_GROUP + A_MODE][3:0];
        ctrl_b.sleep_pfm = regs_q[B_GROUP + A_MODE][5];
    end
endmodule

// ---- b3sp_monitor.sv ----
// Checker for the set-point bank: register port and decoded targets.
// Assumes straps stay steady and the host never writes on two edges in a row.
`timescale 1ns/10ps
module b3sp_monitor
    import b3sp_pkg::*;
(
    // Clock, reset and straps
    input wire logic clk,
    input wire logic reset,
    input wire logic range_strap_a,
    input wire logic range_strap_b,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_hit,
    // Mode and targets
    input wire b3sp_opmode_t opmode_a,
    input wire b3sp_target_t target_a,
    input wire b3sp_target_t target_b
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    a_hit_map: assert property (
        reg_hit == (reg_addr inside {[8'h3c:8'h40], [8'h43:8'h47]}))
        else $error("hit flag disagrees with register map");
    a_unmapped_zero: assert property (reg_rd && !reg_hit |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_mode_unused: assert property (reg_rd && reg_addr inside {8'h3f, 8'h46} |=>
        (reg_rdata & 8'hd0) == 8'h00) else $error("mode unused bits set");
    a_range_read: assert property (reg_rd && reg_addr inside {[8'h3c:8'h3e]} |=>
        reg_rdata[7:6] == {1'b0, range_strap_a}) else $error("range bit read wrong");
    a_write_apply: assert property (reg_wr && reg_addr == 8'h3c && opmode_a == B3SP_NORMAL
        && !(range_strap_a && reg_wdata[5:0] > 6'h32) ##1 opmode_a == B3SP_NORMAL && !reg_wr
        |=> target_a.code == {range_strap_a, $past(reg_wdata[5:0], 2)})
        else $error("normal set point not applied");
    a_decode_mv: assert property (target_a.valid |-> int'(target_a.target_mv) ==
        (target_a.code[6] ? 800 + 50 * target_a.code[5:0] : 400 + 25 * target_a.code[5:0]))
        else $error("target voltage wrong");
    a_no_reserved: assert property (
        target_a.valid |-> !(target_a.code[6] && target_a.code[5:0] > 6'h32))
        else $error("reserved code applied");
    a_range_tgt: assert property (
        target_b.valid |-> target_b.code[6] == range_strap_b)
        else $error("channel b range wrong");
    c_reserved: cover property (reg_wr && reg_addr == 8'h3c && reg_wdata[5:0] > 6'h32);
    c_unmapped: cover property (reg_rd && !reg_hit);
    c_sleep: cover property (opmode_a == B3SP_SLEEP && target_a.valid);
endmodule
bind b3sp_bank b3sp_monitor b3sp_monitor_i (.clk, .reset, .range_strap_a, .range_strap_b,
    .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .opmode_a, .target_a,
    .target_b);

// ---- b3sp_host.sv ----
// Host model: single-byte register writes and reads, driven on falling edges.
// Assumes the bank takes a request on the rising edge and answers one cycle later.
`timescale 1ns/10ps
module b3sp_host (
    // Clock
    input wire logic clk,
    // Register port
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
        @(negedge clk);
        // Released data is inverted so a stale byte never looks valid
        {reg_wr, reg_wdata} = {1'b0, ~d};
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        {reg_rd, reg_addr} = {1'b1, a};
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule

// ---- testbench.sv ----
// Testbench: random register traffic and mode changes against a reference model.
// Assumes straps fixed at start: channel a high range, channel b low range.
`timescale 1ns/10ps
module testbench;
    import b3sp_pkg::*;
    logic clk = 0, reset = 1, range_strap_a = 1, range_strap_b = 0;
    logic reg_wr, reg_rd, reg_hit;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, a, r, e, d;
    b3sp_opmode_t opmode_a = B3SP_NORMAL, opmode_b = B3SP_NORMAL;
    b3sp_chan_ctrl_t ctrl_a, ctrl_b;
    b3sp_target_t target_a, target_b;
    int errors = 0, samples_checked = 0, ma = 0, mb = 0;
    logic [7:0] regs [256];
    logic [6:0] code [2];
    logic [31:0] rnd = 24927;
    always #4 clk = ~clk;
    b3sp_bank b3sp_bank_i (.clk, .reset, .range_strap_a, .range_strap_b, .reg_wr, .reg_rd,
        .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .opmode_a, .opmode_b, .ctrl_a, .ctrl_b,
        .target_a, .target_b);
    b3sp_host b3sp_host_i (.clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
    function automatic logic [31:0] xs(logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        return x ^ (x << 5);
    endfunction
    function automatic logic [7:0] mask(logic [7:0] a);
        return a inside {8'h3f, 8'h46} ? 8'h2f : a inside {8'h40, 8'h47} ? 8'hff :
            a inside {[8'h3c:8'h3e], [8'h43:8'h45]} ? 8'h3f : 8'h00;
    endfunction
    task automatic compare(input logic [19:0] got, input logic [19:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // The design follows the live mode every cycle, so the model is updated after
    // every write as well as at each check
    task automatic upd_code(input bit ch);
        logic [7:0] sp;
        logic s;
        s = ch ? range_strap_b : range_strap_a;
        sp = regs[(ch ? 8'h43 : 8'h3c) + 8'(ch ? mb : ma)];
        if (!(s && sp[5:0] > 6'h32))
            code[ch] = {s, sp[5:0]};
    endtask
    task automatic chk_chan(input bit ch);
        logic [7:0] b;
        logic [11:0] mv;
        b = ch ? 8'h43 : 8'h3c;
        upd_code(ch);
        mv = 12'(code[ch][6] ? 800 + 50 * code[ch][5:0] : 400 + 25 * code[ch][5:0]);
        compare(ch ? target_b : target_a, {code[ch], mv, 1'b1});
        compare(20'(ch ? ctrl_b : ctrl_a), 20'({regs[b + 4][7:2], regs[b + 4][0],
            regs[b + 3][3:0], regs[b + 3][5]}));
    endtask
    task automatic finish_test();
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial
    begin
        regs = '{default: 8'h00};
        code = '{7'h00, 7'h00};
        repeat (4) @(negedge clk);
        reset = 0;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 400; i++)
        begin
            rnd = xs(rnd);
            if (i == 200)
            begin
                // Mid-run reset: registers, strap latch and targets all start over
                reset = 1;
                repeat (2) @(negedge clk);
                reset = 0;
                regs = '{default: 8'h00};
                upd_code(0);
                upd_code(1);
                repeat (2) @(negedge clk);
            end
            // Offsets 0x3c..0x4b, so unmapped holes and the tail are hit as well
            a = 8'h3c + 8'(rnd[3:0]);
            d = rnd[15:8];
            // Channel a runs the high range, where codes below 0x18 give under 2.0 V
            if (range_strap_a && a inside {[8'h3c:8'h3e]} && d[5:0] < 6'h18)
                d[5:0] = d[5:0] + 6'h18;
            if (rnd[17])
            begin
                b3sp_host_i.wr(a, d);
                regs[a] = d & mask(a);
                upd_code(0);
                upd_code(1);
            end
            b3sp_host_i.rd(a, r);
            e = (mask(a) == 8'h3f) ? {1'b0, a > 8'h42 ? range_strap_b : range_strap_a, 6'h00}
                : 8'h00;
            compare(20'(r), 20'(regs[a] | e));
            ma = int'(rnd[21:20]) % 3;
            mb = int'(rnd[23:22]) % 3;
            opmode_a = b3sp_opmode_t'(3'(1 << ma));
            opmode_b = b3sp_opmode_t'(3'(1 << mb));
            repeat (2) @(negedge clk);
            chk_chan(0);
            chk_chan(1);
        end
        finish_test();
    end
endmodule
